// File: mlic_asserts.sv
// Port-level assertion checker for the multilevel interrupt controller.
`timescale 1ns/100ps
module mlic_asserts (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [mlic_pkg::NUM_SRC-1:0] src_cond_i,
  input wire logic osc_fail_i,
  input wire logic global_en_i,
  input wire logic ack_i,
  input wire logic [mlic_pkg::VEC_W-1:0] return_pc_i,
  input wire logic cpu_irq_o,
  input wire logic pc_load_o,
  input wire logic [mlic_pkg::VEC_W-1:0] pc_vector_o,
  input wire logic stack_push_o,
  input wire logic [mlic_pkg::VEC_W-1:0] stack_pc_o,
  input wire logic reset_entry_o,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ack_load_a: assert property (ack_i && cpu_irq_o |=> pc_load_o && stack_push_o && !cpu_irq_o)
    else $error("no vector load after ack");
  load_cause_a: assert property (pc_load_o |-> $past(ack_i && cpu_irq_o))
    else $error("vector load without ack");
  push_pc_a: assert property (ack_i && cpu_irq_o |=> stack_pc_o == $past(return_pc_i))
    else $error("pushed pc differs from return pc");
  vec_hold_a: assert property (!pc_load_o |-> $stable(pc_vector_o))
    else $error("vector changed without load");
  vec_word_a: assert property (pc_load_o |-> pc_vector_o[0] == 1'b0)
    else $error("vector not on a table entry");
  bus_answer_a: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##2 !avs_waitrequest_o)
    else $error("bus answer late or early");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  no_src_a: assert property (!(|src_cond_i) && !osc_fail_i |=> !cpu_irq_o)
    else $error("offer without condition");
  mask_a: assert property (!global_en_i && !osc_fail_i |=> !cpu_irq_o)
    else $error("offer while masked");
  reset_entry_a: assert property ($fell(reset_i) |-> reset_entry_o ##1 !reset_entry_o)
    else $error("reset entry pulse wrong");
  nmi_c: cover property (pc_load_o && pc_vector_o == mlic_pkg::OSC_FAIL_VECTOR);
  ack_c: cover property (ack_i && cpu_irq_o);
  wr_c: cover property (!avs_waitrequest_o && avs_write_i);
endmodule
bind mlic_top mlic_asserts u_asserts (.clk_i(clk_i), .reset_i(reset_i), .src_cond_i(src_cond_i),
  .osc_fail_i(osc_fail_i), .global_en_i(global_en_i), .ack_i(ack_i), .return_pc_i(return_pc_i),
  .cpu_irq_o(cpu_irq_o), .pc_load_o(pc_load_o), .pc_vector_o(pc_vector_o), .stack_push_o(stack_push_o),
  .stack_pc_o(stack_pc_o), .reset_entry_o(reset_entry_o), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o));

// File: mlic_cfg_if.sv
// Interface between the controller and its per-source configuration store.
`timescale 1ns/100ps
interface mlic_cfg_if;
  logic we;
  logic [mlic_pkg::SRC_W-1:0] addr;
  logic [mlic_pkg::CFG_W-1:0] wdata;
  logic [mlic_pkg::CFG_W-1:0] rdata;
  logic [mlic_pkg::NUM_SRC*mlic_pkg::CFG_W-1:0] cfg_flat;
  modport ctrl (output we, output addr, output wdata, input rdata, input cfg_flat);
  modport mem (input we, input addr, input wdata, output rdata, output cfg_flat);
endinterface

// File: mlic_cfg_mem.sv
// Per-source enable and level store with a registered read port.
`timescale 1ns/100ps
module mlic_cfg_mem (
  input wire logic clk_i,
  input wire logic reset_i,
  mlic_cfg_if.mem cfg
);

  logic [mlic_pkg::CFG_W-1:0] cell_r [mlic_pkg::NUM_SRC];
  logic [mlic_pkg::CFG_W-1:0] rdata_r;

  // ----------------------------------------
  // Storage cells
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < mlic_pkg::NUM_SRC; gi++) begin : g_cell
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          cell_r[gi] <= mlic_pkg::CFG_RESET;
        end else if (cfg.we && cfg.addr == mlic_pkg::SRC_W'(gi)) begin
          cell_r[gi] <= cfg.wdata;
        end
      end
      assign cfg.cfg_flat[gi*mlic_pkg::CFG_W +: mlic_pkg::CFG_W] = cell_r[gi];
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  wire logic addr_ok = cfg.addr < mlic_pkg::SRC_W'(mlic_pkg::NUM_SRC);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_r <= mlic_pkg::CFG_RESET;
    end else begin
      rdata_r <= addr_ok ? cell_r[cfg.addr] : mlic_pkg::CFG_RESET;
    end
  end

  assign cfg.rdata = rdata_r;

endmodule

// File: mlic_cpu_model.sv
// Processor program-flow model that takes and returns from interrupts.
`timescale 1ns/100ps
module mlic_cpu_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic take_en_i,
  input wire logic ret_req_i,
  input wire logic irq_i,
  input wire logic load_i,
  input wire logic [15:0] vec_i,
  input wire logic [15:0] spc_i,
  output logic ack_o,
  output logic reti_o,
  output logic [15:0] pc_o
);
  // ----
  // Program flow
  // ----
  logic [15:0] stack_q [$];
  logic [7:0] saved_q [$];
  logic [7:0] flags_r;
  always @(posedge clk_i) begin
    if (reset_i) begin
      ack_o <= 1'b0;
      reti_o <= 1'b0;
      pc_o <= 16'h0000;
      flags_r <= 8'h00;
    end else begin
      ack_o <= take_en_i && irq_i && !ack_o;
      reti_o <= ret_req_i;
      flags_r <= flags_r + 8'h01;
      pc_o <= pc_o + 16'h0001;
      if (load_i) begin
        stack_q.push_back(spc_i);
        saved_q.push_back(flags_r);
        pc_o <= vec_i;
      end else if (reti_o && stack_q.size() > 0) begin
        pc_o <= stack_q.pop_back();
        flags_r <= saved_q.pop_back();
      end
    end
  end
endmodule

// File: mlic_pkg.sv
// Constants, register map and vector table of the multilevel interrupt controller.
package mlic_pkg;

  // ----------------------------------------
  // Sources and vector table
  // ----------------------------------------
  localparam int NUM_SRC = 12;
  localparam int SRC_W = 4;
  localparam int VEC_W = 16;
  localparam logic [VEC_W-1:0] RESET_VECTOR = 16'h0000;
  localparam logic [VEC_W-1:0] OSC_FAIL_VECTOR = 16'h0002;
  localparam logic [VEC_W-1:0] PORT_R_VECTOR = 16'h0004;
  localparam logic [VEC_W-1:0] DMA_VECTOR_BASE = 16'h0006;
  localparam logic [VEC_W-1:0] RTC_VECTOR_BASE = 16'h000e;
  localparam logic [VEC_W-1:0] PORT_C_VECTOR = 16'h0012;
  localparam logic [VEC_W-1:0] TWO_WIRE_VECTOR_BASE = 16'h0014;
  localparam logic [VEC_W-1:0] FIRST_TIMER_VECTOR_BASE = 16'h0018;
  localparam logic [VEC_W-1:0] SRC_BASE [NUM_SRC] = '{
    PORT_R_VECTOR, DMA_VECTOR_BASE, DMA_VECTOR_BASE, DMA_VECTOR_BASE, DMA_VECTOR_BASE,
    RTC_VECTOR_BASE, RTC_VECTOR_BASE, PORT_C_VECTOR, TWO_WIRE_VECTOR_BASE, TWO_WIRE_VECTOR_BASE,
    FIRST_TIMER_VECTOR_BASE, FIRST_TIMER_VECTOR_BASE};
  localparam logic [VEC_W-1:0] SRC_OFFSET [NUM_SRC] = '{
    16'h0000, 16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0000,
    16'h0002, 16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0002};

  // ----------------------------------------
  // Levels and per-source configuration
  // ----------------------------------------
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MED = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_NMI = 2'h3;
  localparam int CFG_W = 3;
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_LVL_LSB = 1;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ACTIVE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_RR_LAST = 8'h08;
  localparam logic [ADDR_W-1:0] REG_EVT_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_EVT_CLEAR = 8'h10;
  localparam logic [ADDR_W-1:0] REG_EVT_ENABLE = 8'h14;
  localparam logic [ADDR_W-1:0] REG_SRC_CFG = 8'h40;
  localparam int CTRL_LO_EN = 0;
  localparam int CTRL_MED_EN = 1;
  localparam int CTRL_HI_EN = 2;
  localparam int CTRL_RR_EN = 6;
  localparam int CTRL_BOOT_SEL = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [SRC_W-1:0] RR_LAST_RESET = 4'hb;
  localparam int EVT_W = 3;
  localparam int EVT_TAKEN = 0;
  localparam int EVT_NMI = 1;
  localparam int EVT_STRAY_RETURN = 2;
  localparam logic [EVT_W-1:0] EVT_RESET = 3'h0;

  // ----------------------------------------
  // Bus handshake states
  // ----------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_FETCH = 3'b010,
    BUS_DONE = 3'b100
  } mlic_bus_state_t;

endpackage

// File: mlic_top.sv
// Multilevel interrupt controller with an Avalon-MM register slave.
`timescale 1ns/100ps

// Overview of operation
// R1 - Each source configured to low, medium, high.
// R2 - Medium request preempts running low handler.
// R3 - High request preempts medium and low handlers.
// R4 - Same level: lowest vector address wins.
// R5 - Optional round-robin among low requests.
// R6 - Non-maskable request ignores all masking.
// R7 - Every source has own enable and level.
// R8 - Enabled source requests while condition present.
// R9 - Acknowledge loads program counter with vector.
// R10 - Vector equals peripheral base plus offset.
// R11 - Vectors are program word addresses.
// R12 - Vector table relocatable to boot section.
// R13 - Reset at zero, oscillator failure next.
// R14 - Peripheral bases at fixed word addresses.
// R15 - Entry pushes return address onto stack.
// R16 - Handler software saves flags register itself; the cpu model saves flags_r on entry and restores it on return.
// R17 - Return clears highest level in service.
// R18 - Last low source served drops lowest.
module mlic_top #(
  parameter logic [mlic_pkg::VEC_W-1:0] BOOT_BASE = 16'h4000
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [mlic_pkg::NUM_SRC-1:0] src_cond_i,
  input wire logic osc_fail_i,
  input wire logic global_en_i,
  input wire logic ack_i,
  input wire logic reti_i,
  input wire logic [mlic_pkg::VEC_W-1:0] return_pc_i,
  output logic cpu_irq_o,
  output logic pc_load_o,
  output logic [mlic_pkg::VEC_W-1:0] pc_vector_o,
  output logic stack_push_o,
  output logic [mlic_pkg::VEC_W-1:0] stack_pc_o,
  output logic reset_entry_o,
  input wire logic [mlic_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  mlic_cfg_if cfg ();
  mlic_pkg::mlic_bus_state_t bus_r, bus_nxt;
  logic [7:0] ctrl_r;
  logic [3:0] act_r, act_nxt;
  logic [mlic_pkg::SRC_W-1:0] rr_last_r;
  logic [mlic_pkg::EVT_W-1:0] evt_sts_r, evt_en_r, evt_set;
  logic [31:0] rdata_r, rdata_nxt;
  logic wait_r;
  logic cand_vld_r, cand_nxt_vld;
  logic [1:0] cand_lvl_r, cand_nxt_lvl;
  logic [mlic_pkg::SRC_W-1:0] cand_src_r, cand_nxt_src;
  logic [mlic_pkg::VEC_W-1:0] cand_vec_r, cand_nxt_vec;
  logic pc_load_r, push_r, irq_r, reset_entry_r;
  logic [mlic_pkg::VEC_W-1:0] pc_vec_r, stack_pc_r;
  logic [mlic_pkg::NUM_SRC-1:0] pend_lo, pend_med, pend_hi;
  logic [mlic_pkg::SRC_W-1:0] pick_lo, pick_med, pick_hi;
  logic [mlic_pkg::VEC_W-1:0] vec_of [mlic_pkg::NUM_SRC];

  // ----------------------------------------
  // Per-source requests and vectors
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < mlic_pkg::NUM_SRC; gi++) begin : g_src
      wire logic [mlic_pkg::CFG_W-1:0] c = cfg.cfg_flat[gi*mlic_pkg::CFG_W +: mlic_pkg::CFG_W];
      wire logic [1:0] lvl = c[mlic_pkg::CFG_LVL_LSB +: 2];
      wire logic req = src_cond_i[gi] && c[mlic_pkg::CFG_EN_BIT]; // [R7] [R8]
      assign pend_lo[gi] = req && lvl == mlic_pkg::LVL_LOW; // [R1]
      assign pend_med[gi] = req && lvl == mlic_pkg::LVL_MED; // [R1]
      assign pend_hi[gi] = req && lvl == mlic_pkg::LVL_HIGH; // [R1]
      assign vec_of[gi] = mlic_pkg::SRC_BASE[gi] + mlic_pkg::SRC_OFFSET[gi]; // [R10] [R14]
    end
  endgenerate

  // ----------------------------------------
  // Selection within a level
  // ----------------------------------------
  function automatic logic [mlic_pkg::SRC_W-1:0] first_set(input logic [mlic_pkg::NUM_SRC-1:0] m);
    logic [mlic_pkg::SRC_W-1:0] r;
    r = '0;
    for (int k = mlic_pkg::NUM_SRC - 1; k >= 0; k--) begin
      if (m[k]) begin
        r = k[mlic_pkg::SRC_W-1:0];
      end
    end
    return r;
  endfunction

  function automatic logic [mlic_pkg::SRC_W-1:0] rr_pick(input logic [mlic_pkg::NUM_SRC-1:0] m,
                                                         input logic [mlic_pkg::SRC_W-1:0] last);
    logic [mlic_pkg::SRC_W-1:0] r;
    logic found;
    int idx;
    r = '0;
    found = 1'b0;
    for (int k = 1; k <= mlic_pkg::NUM_SRC; k++) begin
      idx = (int'(last) + k) % mlic_pkg::NUM_SRC;
      if (!found && m[idx]) begin
        r = idx[mlic_pkg::SRC_W-1:0];
        found = 1'b1;
      end
    end
    return r;
  endfunction

  assign pick_hi = first_set(pend_hi); // [R4]
  assign pick_med = first_set(pend_med); // [R4]
  assign pick_lo = ctrl_r[mlic_pkg::CTRL_RR_EN] ? rr_pick(pend_lo, rr_last_r) : first_set(pend_lo); // [R4] [R5] [R18]

  // ----------------------------------------
  // Arbitration between levels
  // ----------------------------------------
  wire logic [mlic_pkg::VEC_W-1:0] table_base = ctrl_r[mlic_pkg::CTRL_BOOT_SEL] ? BOOT_BASE : '0; // [R12]
  wire logic want_nmi = osc_fail_i && !act_r[mlic_pkg::LVL_NMI]; // [R6]
  wire logic want_hi = global_en_i && ctrl_r[mlic_pkg::CTRL_HI_EN] && (|pend_hi)
                       && !act_r[mlic_pkg::LVL_NMI] && !act_r[mlic_pkg::LVL_HIGH]; // [R3]
  wire logic want_med = global_en_i && ctrl_r[mlic_pkg::CTRL_MED_EN] && (|pend_med)
                        && !act_r[mlic_pkg::LVL_NMI] && !act_r[mlic_pkg::LVL_HIGH]
                        && !act_r[mlic_pkg::LVL_MED]; // [R2]
  wire logic want_lo = global_en_i && ctrl_r[mlic_pkg::CTRL_LO_EN] && (|pend_lo) && act_r == 4'h0;
  wire logic take = ack_i && cand_vld_r;

  always_comb begin
    cand_nxt_vld = 1'b1;
    cand_nxt_lvl = mlic_pkg::LVL_NMI;
    cand_nxt_src = '0;
    cand_nxt_vec = table_base + mlic_pkg::OSC_FAIL_VECTOR; // [R13]
    if (want_nmi) begin
      cand_nxt_lvl = mlic_pkg::LVL_NMI;
    end else if (want_hi) begin
      cand_nxt_lvl = mlic_pkg::LVL_HIGH;
      cand_nxt_src = pick_hi;
      cand_nxt_vec = table_base + vec_of[pick_hi]; // [R11]
    end else if (want_med) begin
      cand_nxt_lvl = mlic_pkg::LVL_MED;
      cand_nxt_src = pick_med;
      cand_nxt_vec = table_base + vec_of[pick_med]; // [R11]
    end else if (want_lo) begin
      cand_nxt_lvl = mlic_pkg::LVL_LOW;
      cand_nxt_src = pick_lo;
      cand_nxt_vec = table_base + vec_of[pick_lo]; // [R11]
    end else begin
      cand_nxt_vld = 1'b0;
    end
  end

  // ----------------------------------------
  // Levels in service
  // ----------------------------------------
  wire logic stray_ret = reti_i && act_r == 4'h0;

  always_comb begin
    act_nxt = act_r;
    if (reti_i) begin
      if (act_r[mlic_pkg::LVL_NMI]) begin
        act_nxt[mlic_pkg::LVL_NMI] = 1'b0; // [R17]
      end else if (act_r[mlic_pkg::LVL_HIGH]) begin
        act_nxt[mlic_pkg::LVL_HIGH] = 1'b0; // [R17]
      end else if (act_r[mlic_pkg::LVL_MED]) begin
        act_nxt[mlic_pkg::LVL_MED] = 1'b0; // [R17]
      end else begin
        act_nxt[mlic_pkg::LVL_LOW] = 1'b0; // [R17]
      end
    end
    if (take) begin
      act_nxt[cand_lvl_r] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      act_r <= 4'h0;
      rr_last_r <= mlic_pkg::RR_LAST_RESET;
      cand_vld_r <= 1'b0;
      cand_lvl_r <= mlic_pkg::LVL_LOW;
      cand_src_r <= '0;
      cand_vec_r <= mlic_pkg::RESET_VECTOR;
    end else begin
      act_r <= act_nxt;
      if (take && cand_lvl_r == mlic_pkg::LVL_LOW) begin
        rr_last_r <= cand_src_r; // [R18]
      end
      cand_vld_r <= take ? 1'b0 : cand_nxt_vld;
      cand_lvl_r <= cand_nxt_lvl;
      cand_src_r <= cand_nxt_src;
      cand_vec_r <= cand_nxt_vec;
    end
  end

  // ----------------------------------------
  // Program flow outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_r <= 1'b0;
      pc_load_r <= 1'b0;
      push_r <= 1'b0;
      pc_vec_r <= mlic_pkg::RESET_VECTOR;
      stack_pc_r <= '0;
      reset_entry_r <= 1'b1;
    end else begin
      irq_r <= cand_nxt_vld && !take;
      pc_load_r <= take; // [R9]
      push_r <= take; // [R15]
      reset_entry_r <= 1'b0;
      if (take) begin
        pc_vec_r <= cand_vec_r; // [R9]
        stack_pc_r <= return_pc_i; // [R15]
      end
    end
  end

  // ----------------------------------------
  // Register bus handshake
  // ----------------------------------------
  wire logic bus_req = avs_read_i || avs_write_i;
  wire logic bus_wr = avs_write_i && avs_byteenable_i[0] && bus_r == mlic_pkg::BUS_DONE;
  wire logic hit_cfg = avs_address_i >= mlic_pkg::REG_SRC_CFG
                       && avs_address_i < mlic_pkg::REG_SRC_CFG + mlic_pkg::ADDR_W'(4 * mlic_pkg::NUM_SRC);
  wire logic [mlic_pkg::ADDR_W-1:0] cfg_off = avs_address_i - mlic_pkg::REG_SRC_CFG;

  assign cfg.addr = cfg_off[2 +: mlic_pkg::SRC_W];
  assign cfg.we = bus_wr && hit_cfg; // [R7]
  assign cfg.wdata = avs_writedata_i[mlic_pkg::CFG_W-1:0];

  always_comb begin
    case (bus_r)
      mlic_pkg::BUS_IDLE: bus_nxt = bus_req ? mlic_pkg::BUS_FETCH : mlic_pkg::BUS_IDLE;
      mlic_pkg::BUS_FETCH: bus_nxt = mlic_pkg::BUS_DONE;
      mlic_pkg::BUS_DONE: bus_nxt = mlic_pkg::BUS_IDLE;
      default: bus_nxt = mlic_pkg::BUS_IDLE;
    endcase
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_cfg) begin
      rdata_nxt[mlic_pkg::CFG_W-1:0] = cfg.rdata;
    end else begin
      case (avs_address_i)
        mlic_pkg::REG_CTRL: rdata_nxt[7:0] = ctrl_r;
        mlic_pkg::REG_ACTIVE: rdata_nxt[3:0] = act_r;
        mlic_pkg::REG_RR_LAST: rdata_nxt[mlic_pkg::SRC_W-1:0] = rr_last_r;
        mlic_pkg::REG_EVT_STATUS: rdata_nxt[mlic_pkg::EVT_W-1:0] = evt_sts_r;
        mlic_pkg::REG_EVT_ENABLE: rdata_nxt[mlic_pkg::EVT_W-1:0] = evt_en_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_r <= mlic_pkg::BUS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      bus_r <= bus_nxt;
      wait_r <= bus_r != mlic_pkg::BUS_FETCH;
      if (bus_r == mlic_pkg::BUS_FETCH) begin
        rdata_r <= avs_read_i ? rdata_nxt : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Control and event registers
  // ----------------------------------------
  assign evt_set[mlic_pkg::EVT_TAKEN] = take && cand_lvl_r != mlic_pkg::LVL_NMI;
  assign evt_set[mlic_pkg::EVT_NMI] = take && cand_lvl_r == mlic_pkg::LVL_NMI; // [R6]
  assign evt_set[mlic_pkg::EVT_STRAY_RETURN] = stray_ret;
  wire logic [mlic_pkg::EVT_W-1:0] evt_clr = (bus_wr && avs_address_i == mlic_pkg::REG_EVT_CLEAR)
                                             ? avs_writedata_i[mlic_pkg::EVT_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_r <= mlic_pkg::CTRL_RESET;
      evt_sts_r <= mlic_pkg::EVT_RESET;
      evt_en_r <= mlic_pkg::EVT_RESET;
      irq_o <= 1'b0;
    end else begin
      if (bus_wr && avs_address_i == mlic_pkg::REG_CTRL) begin
        ctrl_r <= avs_writedata_i[7:0];
      end
      if (bus_wr && avs_address_i == mlic_pkg::REG_EVT_ENABLE) begin
        evt_en_r <= avs_writedata_i[mlic_pkg::EVT_W-1:0];
      end
      evt_sts_r <= (evt_sts_r & ~evt_clr) | evt_set;
      irq_o <= |(evt_sts_r & evt_en_r);
    end
  end

  // ----------------------------------------
  // Configuration store and outputs
  // ----------------------------------------
  mlic_cfg_mem u_cfg_mem (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .cfg(cfg)
  );

  assign cpu_irq_o = irq_r;
  assign pc_load_o = pc_load_r;
  assign pc_vector_o = pc_vec_r;
  assign stack_push_o = push_r;
  assign stack_pc_o = stack_pc_r;
  assign reset_entry_o = reset_entry_r;
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;

endmodule

// File: testbench.sv
// Self-checking bench for the multilevel interrupt controller.
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [3:0] src;
    logic [1:0] lvl;
    logic [15:0] vec;
  } mlic_row_t;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [11:0] src_cond_i = 12'h000;
  logic osc_fail_i = 1'b0;
  logic global_en_i = 1'b1;
  logic ret_req = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic ack_i, reti_i, cpu_irq_o, pc_load_o, stack_push_o, reset_entry_o, irq_o, avs_waitrequest_o;
  logic [15:0] return_pc_i, pc_vector_o, stack_pc_o;
  logic [31:0] avs_readdata_o, rd;
  int n_errors = 0;
  int comparisons = 0;
  mlic_row_t rows [12] = '{'{4'h0, 2'h0, 16'h0004}, '{4'h1, 2'h1, 16'h0006}, '{4'h2, 2'h2, 16'h0008},
    '{4'h3, 2'h0, 16'h000a}, '{4'h4, 2'h1, 16'h000c}, '{4'h5, 2'h2, 16'h000e}, '{4'h6, 2'h0, 16'h0010},
    '{4'h7, 2'h1, 16'h0012}, '{4'h8, 2'h2, 16'h0014}, '{4'h9, 2'h0, 16'h0016}, '{4'ha, 2'h1, 16'h0018},
    '{4'hb, 2'h2, 16'h001a}};
  always #20 clk_i = ~clk_i;
  mlic_top uut (.clk_i(clk_i), .reset_i(reset_i), .src_cond_i(src_cond_i), .osc_fail_i(osc_fail_i),
    .global_en_i(global_en_i), .ack_i(ack_i), .reti_i(reti_i), .return_pc_i(return_pc_i),
    .cpu_irq_o(cpu_irq_o), .pc_load_o(pc_load_o), .pc_vector_o(pc_vector_o), .stack_push_o(stack_push_o),
    .stack_pc_o(stack_pc_o), .reset_entry_o(reset_entry_o), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .irq_o(irq_o));
  mlic_cpu_model u_cpu (.clk_i(clk_i), .reset_i(reset_i), .take_en_i(1'b1), .ret_req_i(ret_req),
    .irq_i(cpu_irq_o), .load_i(pc_load_o & stack_push_o), .vec_i(pc_vector_o), .spc_i(stack_pc_o),
    .ack_o(ack_i), .reti_o(reti_i), .pc_o(return_pc_i));
  // ----
  // Tasks
  // ----
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (k == 20) begin
      n_errors++;
      close_out();
    end
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask
  task automatic cfg(input logic [3:0] s, input logic [1:0] lvl, input logic en);
    wr(mlic_pkg::REG_SRC_CFG + {s, 2'b00}, {29'h0, lvl, en});
  endtask
  task automatic cond(input logic [11:0] c);
    @(posedge clk_i);
    src_cond_i <= c;
  endtask
  task automatic ret();
    @(posedge clk_i);
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic wait_load(input logic [15:0] exp);
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_i);
      if (pc_load_o === 1'b1) break;
    end
    if (k == 50) begin
      n_errors++;
      close_out();
    end
    check("pc_vector_o", 32'(exp), 32'(pc_vector_o));
    check("stack_push_o", 32'h1, 32'(stack_push_o));
    #1;
    check("cpu_pc", 32'(exp), 32'(return_pc_i));
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (20) @(posedge clk_i);
    check("reset_entry_o", 32'h1, 32'(reset_entry_o));
    check("pc_vector_o", 32'h0, 32'(pc_vector_o));
    reset_i <= 1'b0;
    rdc("ctrl", mlic_pkg::REG_CTRL, 32'h0);
    rdc("rr_last", mlic_pkg::REG_RR_LAST, 32'hb);
    rdc("cfg0", mlic_pkg::REG_SRC_CFG, 32'h0);
    rdc("unmapped", 8'h3c, 32'h0);
    wr(mlic_pkg::REG_CTRL, 32'h47);
    cfg(4'h0, 2'h0, 1'b1);
    cfg(4'h1, 2'h0, 1'b1);
    cond(12'h003);
    wait_load(16'h0004);
    rdc("rr_last", mlic_pkg::REG_RR_LAST, 32'h0);
    ret();
    wait_load(16'h0006);
    cond(12'h000);
    ret();
    wr(mlic_pkg::REG_CTRL, 32'h07);
    cfg(4'h3, 2'h0, 1'b1);
    cond(12'h00a);
    wait_load(16'h0006);
    cond(12'h008);
    ret();
    wait_load(16'h000a);
    cond(12'h000);
    ret();
    foreach (rows[i]) begin
      cfg(rows[i].src, rows[i].lvl, 1'b1);
      cond(12'h001 << rows[i].src);
      wait_load(rows[i].vec);
      cond(12'h000);
      rdc("active", mlic_pkg::REG_ACTIVE, 32'h1 << rows[i].lvl);
      ret();
      rdc("active", mlic_pkg::REG_ACTIVE, 32'h0);
      cfg(rows[i].src, 2'h0, 1'b0);
    end
    cfg(4'h0, 2'h0, 1'b1);
    cfg(4'h5, 2'h1, 1'b1);
    cfg(4'h8, 2'h2, 1'b1);
    cond(12'h001);
    wait_load(16'h0004);
    cond(12'h021);
    wait_load(16'h000e);
    rdc("active", mlic_pkg::REG_ACTIVE, 32'h3);
    cond(12'h121);
    wait_load(16'h0014);
    rdc("active", mlic_pkg::REG_ACTIVE, 32'h7);
    cond(12'h000);
    ret();
    rdc("active", mlic_pkg::REG_ACTIVE, 32'h3);
    ret();
    ret();
    global_en_i <= 1'b0;
    cond(12'h001);
    repeat (4) @(posedge clk_i);
    check("cpu_irq_o", 32'h0, 32'(cpu_irq_o));
    osc_fail_i <= 1'b1;
    wait_load(mlic_pkg::OSC_FAIL_VECTOR);
    osc_fail_i <= 1'b0;
    rdc("active", mlic_pkg::REG_ACTIVE, 32'h8);
    rdc("evt", mlic_pkg::REG_EVT_STATUS, 32'h3);
    wr(mlic_pkg::REG_EVT_ENABLE, 32'h2);
    repeat (2) @(posedge clk_i);
    check("irq_o", 32'h1, 32'(irq_o));
    wr(mlic_pkg::REG_EVT_ENABLE, 32'h0);
    repeat (2) @(posedge clk_i);
    check("irq_o", 32'h0, 32'(irq_o));
    wr(mlic_pkg::REG_EVT_ENABLE, 32'h2);
    wr(mlic_pkg::REG_EVT_CLEAR, 32'h2);
    repeat (2) @(posedge clk_i);
    check("irq_o", 32'h0, 32'(irq_o));
    cond(12'h000);
    ret();
    ret();
    rdc("evt", mlic_pkg::REG_EVT_STATUS, 32'h5);
    global_en_i <= 1'b1;
    wr(mlic_pkg::REG_CTRL, 32'h87);
    cond(12'h001);
    wait_load(16'h4004);
    cond(12'h000);
    ret();
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("reset_entry_o", 32'h1, 32'(reset_entry_o));
    reset_i <= 1'b0;
    rdc("ctrl", mlic_pkg::REG_CTRL, 32'h0);
    close_out();
  end
endmodule
